// ===== ahs_comm.sv
// Commutation decoder: mechanical angle and pole-pair setting to three phase outputs.
`timescale 1ns/100ps
module ahs_comm (
  // Angle and setting.
  input  wire logic [ahs_pkg::ANGLE_W-1:0]  angle_i,
  input  wire logic [ahs_pkg::POLE_W-1:0]   pole_field_i,
  // Phase outputs.
  output logic      [2:0]                   uvw_o
);

  logic [ahs_pkg::POLE_W:0]    pairs_w;
  logic [ahs_pkg::ANGLE_W-1:0] elec_w;
  logic [ahs_pkg::ANGLE_W+2:0] sect_prod_w;
  logic [2:0]                  sector_w;

  assign pairs_w     = {1'b0, pole_field_i} + 5'h01;
  assign elec_w      = ahs_pkg::ANGLE_W'(angle_i * pairs_w);
  assign sect_prod_w = {3'h0, elec_w} * 17'h00006;
  assign sector_w    = sect_prod_w[ahs_pkg::ANGLE_W+2:ahs_pkg::ANGLE_W];

  always_comb
  begin
    case (sector_w)
      3'h0:    uvw_o = 3'h5;
      3'h1:    uvw_o = 3'h4;
      3'h2:    uvw_o = 3'h6;
      3'h3:    uvw_o = 3'h2;
      3'h4:    uvw_o = 3'h3;
      3'h5:    uvw_o = 3'h1;
      default: uvw_o = 3'h5;
    endcase
  end

endmodule

// ===== ahs_host_model.sv
// Host controller model that decodes the quadrature encoder lines.
`timescale 1ns/100ps
module ahs_host_model (
  // Clock and reset.
  input  wire logic        core_clk_i,
  input  wire logic        nrst_i,
  // Encoder lines.
  input  wire logic        enc_a_i,
  input  wire logic        enc_b_i,
  // Decoded position and count of illegal transitions.
  output logic      [11:0] pos_o,
  output logic      [7:0]  err_o
);
  logic [15:0] age_reg;
  logic [1:0]  q_reg;
  logic [1:0]  q_now;
  logic [1:0]  step;
  assign q_now = {enc_b_i, enc_a_i ^ enc_b_i};
  assign step  = q_now - q_reg;
  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      age_reg <= 16'h0000;
      q_reg   <= 2'h0;
      pos_o   <= 12'h000;
      err_o   <= 8'h00;
    end
    else
    begin
      q_reg <= q_now;
      if (age_reg < 16'(ahs_pkg::POWER_ON_CYCLES + 2))
        age_reg <= age_reg + 16'h0001;
      else if (step == 2'h1)
        pos_o <= pos_o + 12'h001;
      else if (step == 2'h3)
        pos_o <= pos_o - 12'h001;
      else if (step == 2'h2)
        err_o <= err_o + 8'h01;
    end
  end
endmodule

// ===== ahs_hyst.sv
// Hysteresis filter on the compensated angle with direction tracking.
`timescale 1ns/100ps
module ahs_hyst (
  // Clock and reset.
  input  wire logic                          core_clk_i,
  input  wire logic                          nrst_i,
  // Angle samples.
  input  wire logic [ahs_pkg::ANGLE_W-1:0]   angle_i,
  input  wire logic                          angle_valid_i,
  // Control.
  input  wire logic [ahs_pkg::HYST_W-1:0]    hysteresis_window_width_i,
  input  wire logic                          reinit_i,
  // Filtered result.
  output logic      [ahs_pkg::ANGLE_W-1:0]   filt_o,
  output logic                               dir_o
);

  logic [ahs_pkg::ANGLE_W-1:0] filt_reg;
  logic [ahs_pkg::ANGLE_W-1:0] filt_next;
  logic                        dir_reg;
  logic                        dir_next;
  logic                        init_reg;
  logic                        init_next;
  logic [ahs_pkg::ANGLE_W-1:0] diff_w;
  logic [ahs_pkg::ANGLE_W-1:0] ndiff_w;
  logic [ahs_pkg::ANGLE_W-1:0] width_w;
  logic                        ahead_w;
  logic                        exit_tail_w;

  assign diff_w  = angle_i - filt_reg;
  assign ndiff_w = filt_reg - angle_i;
  assign width_w = {{(ahs_pkg::ANGLE_W-ahs_pkg::HYST_W){1'b0}}, hysteresis_window_width_i};
  assign ahead_w = dir_reg ? (ndiff_w != '0 && !ndiff_w[ahs_pkg::ANGLE_W-1])
                           : (diff_w != '0 && !diff_w[ahs_pkg::ANGLE_W-1]);
  assign exit_tail_w = dir_reg ? (!diff_w[ahs_pkg::ANGLE_W-1] && diff_w > width_w)
                               : (!ndiff_w[ahs_pkg::ANGLE_W-1] && ndiff_w > width_w);

  always_comb
  begin
    filt_next = filt_reg;
    dir_next  = dir_reg;
    init_next = init_reg;
    if (reinit_i)
    begin
      init_next = 1'b1;
      dir_next  = 1'b0;
    end
    else if (angle_valid_i)
    begin
      if (init_reg)
      begin
        filt_next = angle_i;
        dir_next  = 1'b0;
        init_next = 1'b0;
      end
      else if (ahead_w)
      begin
        filt_next = angle_i;
      end
      else if (exit_tail_w)
      begin
        filt_next = angle_i;
        dir_next  = !dir_reg;
      end
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      filt_reg <= '0;
      dir_reg  <= 1'b0;
      init_reg <= 1'b1;
    end
    else
    begin
      filt_reg <= filt_next;
      dir_reg  <= dir_next;
      init_reg <= init_next;
    end
  end

  assign filt_o = filt_reg;
  assign dir_o  = dir_reg;

  dir_reinit_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    reinit_i |=> !dir_o ##1 (!dir_o || angle_valid_i))
    else $error("direction not reset to increasing after reinit");

  follow_head_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (angle_valid_i && !reinit_i && !init_reg && ahead_w) |=> filt_o == $past(angle_i))
    else $error("filtered angle did not follow the advancing angle");

  freeze_window_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (angle_valid_i && !reinit_i && !init_reg && !ahead_w && !exit_tail_w)
      |=> $stable(filt_o) && $stable(dir_o))
    else $error("filtered angle moved inside the window");

  flip_head_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (angle_valid_i && !reinit_i && !init_reg && exit_tail_w) |=> dir_o != $past(dir_o))
    else $error("direction did not flip on tail exit");

  trail_start_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (angle_valid_i && !reinit_i && init_reg) |=> !dir_o && filt_o == $past(angle_i))
    else $error("window not placed trailing the initial angle");

endmodule

// ===== ahs_pkg.sv
// Shared constants and types for the angle hysteresis and encoder start-up block.
package ahs_pkg;

  // Widths of the angle path, the sequence timer and the register port.
  localparam int ANGLE_W = 14;
  localparam int QUAD_W  = 12;
  localparam int POLE_W  = 4;
  localparam int HYST_W  = 6;
  localparam int ADDR_W  = 8;
  localparam int DATA_W  = 16;
  localparam int TMR_W   = 16;

  // Register offsets.
  localparam logic [ADDR_W-1:0] CFG_OFS  = 8'h00;
  localparam logic [ADDR_W-1:0] STEP_OFS = 8'h04;
  localparam logic [ADDR_W-1:0] HYST_OFS = 8'h08;
  localparam logic [ADDR_W-1:0] STAT_OFS = 8'h0C;
  localparam logic [ADDR_W-1:0] FILT_OFS = 8'h10;

  // Field positions.
  localparam int CFG_POLE_LSB  = 0;
  localparam int CFG_AHE_BIT   = 4;
  localparam int STAT_DIR_BIT  = 0;
  localparam int STAT_DONE_BIT = 1;

  // Reset values.
  localparam logic [POLE_W-1:0] POLE_RST = 4'h0;
  localparam logic              AHE_RST  = 1'b0;
  localparam logic [DATA_W-1:0] STEP_RST = 16'h0000;
  localparam logic [HYST_W-1:0] HYST_RST = 6'h00;

  // Start-up timing.
  localparam int CLK_PERIOD_NS     = 5;
  localparam int POWER_ON_TIME_NS  = 1000;
  localparam int DELAY_TIME_NS     = 2000;
  localparam int POWER_ON_CYCLES   = (POWER_ON_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_CYCLES      = (DELAY_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [TMR_W-1:0] POWER_ON_LAST = TMR_W'(POWER_ON_CYCLES - 1);
  localparam logic [TMR_W-1:0] DELAY_LAST    = TMR_W'(DELAY_CYCLES - 1);

  // Phases of the encoder output sequence.
  typedef enum logic [1:0] {
    ST_POWER_ON,
    ST_HOLD,
    ST_CATCH,
    ST_RUN
  } ahs_phase_type;

endpackage

// ===== ahs_top.sv
// Angle output logic: hysteresis, encoder start-up and slew, commutation and registers.
`timescale 1ns/100ps
module ahs_top (
  // Clock and reset.
  input  wire logic                          core_clk_i,
  input  wire logic                          nrst_i,
  // Angle samples and self-test completion.
  input  wire logic [ahs_pkg::ANGLE_W-1:0]   angle_i,
  input  wire logic                          angle_valid_i,
  input  wire logic                          self_test_done_i,
  // Register port.
  input  wire logic [ahs_pkg::ADDR_W-1:0]    addr_i,
  input  wire logic [ahs_pkg::DATA_W-1:0]    wr_data_i,
  input  wire logic                          wr_i,
  input  wire logic                          rd_i,
  output logic      [ahs_pkg::DATA_W-1:0]    rd_data_o,
  // Quadrature encoder outputs.
  output logic                               enc_a_o,
  output logic                               enc_b_o,
  output logic                               enc_idx_o,
  // Commutation outputs.
  output logic                               comm_u_o,
  output logic                               comm_v_o,
  output logic                               comm_w_o
);

  // Configuration registers.
  logic [ahs_pkg::POLE_W-1:0]  pole_reg;
  logic [ahs_pkg::POLE_W-1:0]  pole_next;
  logic                        ahe_reg;
  logic                        ahe_next;
  logic [ahs_pkg::DATA_W-1:0]  step_reg;
  logic [ahs_pkg::DATA_W-1:0]  step_next;
  logic [ahs_pkg::HYST_W-1:0]  hyst_reg;
  logic [ahs_pkg::HYST_W-1:0]  hyst_next;
  logic [ahs_pkg::DATA_W-1:0]  rd_data_reg;
  logic [ahs_pkg::DATA_W-1:0]  rd_data_next;

  // Angle path.
  logic [ahs_pkg::ANGLE_W-1:0] angle_reg;
  logic [ahs_pkg::ANGLE_W-1:0] angle_next;
  logic [ahs_pkg::ANGLE_W-1:0] filt_w;
  logic                        dir_w;
  logic [ahs_pkg::ANGLE_W-1:0] src_w;
  logic [ahs_pkg::QUAD_W-1:0]  target_w;
  logic [2:0]                  uvw_w;

  // Encoder sequence state.
  ahs_pkg::ahs_phase_type      phase_reg;
  ahs_pkg::ahs_phase_type      phase_next;
  logic [ahs_pkg::TMR_W-1:0]   tmr_reg;
  logic [ahs_pkg::TMR_W-1:0]   tmr_next;
  logic [ahs_pkg::DATA_W-1:0]  slew_cnt_reg;
  logic [ahs_pkg::DATA_W-1:0]  slew_cnt_next;
  logic [ahs_pkg::QUAD_W-1:0]  pos_reg;
  logic [ahs_pkg::QUAD_W-1:0]  pos_next;
  logic                        done_reg;
  logic                        done_next;
  logic [ahs_pkg::QUAD_W-1:0]  diff_w;
  logic                        slew_due_w;

  // Output flip-flops.
  logic                        enc_a_reg;
  logic                        enc_a_next;
  logic                        enc_b_reg;
  logic                        enc_b_next;
  logic                        enc_idx_reg;
  logic                        enc_idx_next;
  logic [2:0]                  uvw_reg;
  logic [2:0]                  uvw_next;

  ahs_hyst u_hyst (
    .core_clk_i                (core_clk_i),
    .nrst_i                    (nrst_i),
    .angle_i                   (angle_i),
    .angle_valid_i             (angle_valid_i),
    .hysteresis_window_width_i (hyst_reg),
    .reinit_i                  (self_test_done_i),
    .filt_o                    (filt_w),
    .dir_o                     (dir_w)
  );

  ahs_comm u_comm (
    .angle_i      (src_w),
    .pole_field_i (pole_reg),
    .uvw_o        (uvw_w)
  );

  // Register port: writes, and read data in the cycle after the strobe.
  always_comb
  begin
    pole_next    = pole_reg;
    ahe_next     = ahe_reg;
    step_next    = step_reg;
    hyst_next    = hyst_reg;
    rd_data_next = '0;
    if (wr_i)
    begin
      case (addr_i)
        ahs_pkg::CFG_OFS:
        begin
          pole_next = wr_data_i[ahs_pkg::CFG_POLE_LSB +: ahs_pkg::POLE_W];
          ahe_next  = wr_data_i[ahs_pkg::CFG_AHE_BIT];
        end
        ahs_pkg::STEP_OFS: step_next = wr_data_i;
        ahs_pkg::HYST_OFS: hyst_next = wr_data_i[ahs_pkg::HYST_W-1:0];
        default: ;
      endcase
    end
    if (rd_i)
    begin
      case (addr_i)
        ahs_pkg::CFG_OFS:
        begin
          rd_data_next[ahs_pkg::CFG_POLE_LSB +: ahs_pkg::POLE_W] = pole_reg;
          rd_data_next[ahs_pkg::CFG_AHE_BIT] = ahe_reg;
        end
        ahs_pkg::STEP_OFS: rd_data_next = step_reg;
        ahs_pkg::HYST_OFS: rd_data_next[ahs_pkg::HYST_W-1:0] = hyst_reg;
        ahs_pkg::STAT_OFS:
        begin
          rd_data_next[ahs_pkg::STAT_DIR_BIT]  = dir_w;
          rd_data_next[ahs_pkg::STAT_DONE_BIT] = done_reg;
        end
        ahs_pkg::FILT_OFS: rd_data_next[11:0] = filt_w[ahs_pkg::ANGLE_W-1:2];
        default: rd_data_next = '0;
      endcase
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      pole_reg    <= ahs_pkg::POLE_RST;
      ahe_reg     <= ahs_pkg::AHE_RST;
      step_reg    <= ahs_pkg::STEP_RST;
      hyst_reg    <= ahs_pkg::HYST_RST;
      rd_data_reg <= '0;
    end
    else
    begin
      pole_reg    <= pole_next;
      ahe_reg     <= ahe_next;
      step_reg    <= step_next;
      hyst_reg    <= hyst_next;
      rd_data_reg <= rd_data_next;
    end
  end

  // Latest raw sample, and the angle that drives the outputs.
  always_comb
  begin
    angle_next = angle_valid_i ? angle_i : angle_reg;
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      angle_reg <= '0;
    end
    else
    begin
      angle_reg <= angle_next;
    end
  end

  assign src_w      = ahe_reg ? filt_w : angle_reg;
  assign target_w   = src_w[ahs_pkg::ANGLE_W-1:ahs_pkg::ANGLE_W-ahs_pkg::QUAD_W];
  assign diff_w     = target_w - pos_reg;
  assign slew_due_w = slew_cnt_reg >= (step_reg - 16'h0001);

  // Encoder sequence: power-on, zero hold, catch-up, normal run.
  always_comb
  begin
    phase_next    = phase_reg;
    tmr_next      = tmr_reg;
    slew_cnt_next = slew_cnt_reg;
    pos_next      = pos_reg;
    done_next     = done_reg;
    case (phase_reg)
      ahs_pkg::ST_POWER_ON:
      begin
        tmr_next = tmr_reg + 16'h0001;
        if (tmr_reg == ahs_pkg::POWER_ON_LAST)
        begin
          tmr_next   = '0;
          pos_next   = '0;
          phase_next = ahs_pkg::ST_HOLD;
        end
      end
      ahs_pkg::ST_HOLD:
      begin
        tmr_next = tmr_reg + 16'h0001;
        pos_next = '0;
        if (tmr_reg == ahs_pkg::DELAY_LAST)
        begin
          tmr_next = '0;
          if (step_reg == '0)
          begin
            pos_next   = target_w;
            done_next  = 1'b1;
            phase_next = ahs_pkg::ST_RUN;
          end
          else
          begin
            phase_next = ahs_pkg::ST_CATCH;
          end
        end
      end
      ahs_pkg::ST_CATCH, ahs_pkg::ST_RUN:
      begin
        if (step_reg == '0)
        begin
          pos_next      = target_w;
          slew_cnt_next = '0;
        end
        else if (diff_w == '0)
        begin
          slew_cnt_next = '0;
        end
        else if (slew_due_w)
        begin
          slew_cnt_next = '0;
          if (diff_w[ahs_pkg::QUAD_W-1])
          begin
            pos_next = pos_reg - 12'h001;
          end
          else
          begin
            pos_next = pos_reg + 12'h001;
          end
        end
        else
        begin
          slew_cnt_next = slew_cnt_reg + 16'h0001;
        end
        if (phase_reg == ahs_pkg::ST_CATCH && pos_next == target_w)
        begin
          done_next  = 1'b1;
          phase_next = ahs_pkg::ST_RUN;
        end
      end
      default:
      begin
        phase_next = ahs_pkg::ST_POWER_ON;
        tmr_next   = '0;
      end
    endcase
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      phase_reg    <= ahs_pkg::ST_POWER_ON;
      tmr_reg      <= '0;
      slew_cnt_reg <= '0;
      pos_reg      <= '0;
      done_reg     <= 1'b0;
    end
    else
    begin
      phase_reg    <= phase_next;
      tmr_reg      <= tmr_next;
      slew_cnt_reg <= slew_cnt_next;
      pos_reg      <= pos_next;
      done_reg     <= done_next;
    end
  end

  // Encoder flops track the next position, commutation flops the decoded angle; both line up with the phase.
  always_comb
  begin
    enc_a_next   = 1'b0;
    enc_b_next   = 1'b0;
    enc_idx_next = 1'b0;
    uvw_next     = 3'h0;
    if (phase_next != ahs_pkg::ST_POWER_ON)
    begin
      enc_a_next   = pos_next[1] ^ pos_next[0];
      enc_b_next   = pos_next[1];
      enc_idx_next = (pos_next == '0);
      uvw_next     = uvw_w;
    end
  end

  always_ff @(posedge core_clk_i)
  begin
    if (!nrst_i)
    begin
      enc_a_reg   <= 1'b0;
      enc_b_reg   <= 1'b0;
      enc_idx_reg <= 1'b0;
      uvw_reg     <= 3'h0;
    end
    else
    begin
      enc_a_reg   <= enc_a_next;
      enc_b_reg   <= enc_b_next;
      enc_idx_reg <= enc_idx_next;
      uvw_reg     <= uvw_next;
    end
  end

  assign rd_data_o = rd_data_reg;
  assign enc_a_o   = enc_a_reg;
  assign enc_b_o   = enc_b_reg;
  assign enc_idx_o = enc_idx_reg;
  assign comm_u_o  = uvw_reg[2];
  assign comm_v_o  = uvw_reg[1];
  assign comm_w_o  = uvw_reg[0];

  hold_zero_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    phase_reg == ahs_pkg::ST_HOLD |-> !enc_a_o && !enc_b_o && enc_idx_o)
    else $error("encoder not at zero angle during hold");

  one_line_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (phase_reg == ahs_pkg::ST_CATCH && step_reg != '0)
      |=> (enc_a_o != $past(enc_a_o)) + (enc_b_o != $past(enc_b_o)) <= 1)
    else $error("both quadrature lines changed in one step");

  shorter_way_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (phase_reg == ahs_pkg::ST_CATCH && step_reg != '0 && diff_w != '0 && slew_due_w)
      |=> pos_reg == ($past(diff_w[11]) ? $past(pos_reg) - 12'h001 : $past(pos_reg) + 12'h001))
    else $error("catch-up stepped the long way");

  step_rate_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    ((phase_reg == ahs_pkg::ST_CATCH || phase_reg == ahs_pkg::ST_RUN) && step_reg == 16'h0003
      && diff_w != '0 && slew_cnt_reg == '0 && !wr_i)
      |=> $stable(pos_reg) ##1 $stable(pos_reg))
    else $error("encoder stepped faster than the step interval");

  jump_direct_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (phase_reg == ahs_pkg::ST_RUN && step_reg == '0) |=> pos_reg == $past(target_w))
    else $error("zero interval did not drive position directly");

  status_dir_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ahs_pkg::STAT_OFS) |=> rd_data_o[0] == $past(dir_w))
    else $error("status read does not show direction");

  filt_read_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (rd_i && addr_i == ahs_pkg::FILT_OFS) |=> rd_data_o == {4'h0, $past(filt_w[13:2])})
    else $error("filtered angle readback wrong");

  src_select_a : assert property (@(posedge core_clk_i) disable iff (!nrst_i)
    (ahe_reg && phase_reg == ahs_pkg::ST_RUN && step_reg == '0) |=> pos_reg == $past(filt_w[13:2]))
    else $error("outputs not driven from filtered angle");

endmodule

// ===== tb_ahs_top.sv
// Self-checking testbench for the angle output block.
`timescale 1ns/100ps
module tb_ahs_top;
  typedef struct packed {
    logic [13:0] ang;
    logic [11:0] filt;
    logic        dir;
  } ahs_row_type;
  logic                        core_clk_i;
  logic                        nrst_i;
  logic [ahs_pkg::ANGLE_W-1:0] angle_i;
  logic                        angle_valid_i;
  logic                        self_test_done_i;
  logic [ahs_pkg::ADDR_W-1:0]  addr_i;
  logic [ahs_pkg::DATA_W-1:0]  wr_data_i;
  logic                        wr_i;
  logic                        rd_i;
  logic [ahs_pkg::DATA_W-1:0]  rd_data_o;
  logic                        enc_a_o, enc_b_o, enc_idx_o;
  logic                        comm_u_o, comm_v_o, comm_w_o;
  logic [11:0]                 host_pos;
  logic [7:0]                  host_err;
  logic [15:0]                 d;
  logic [2:0]                  uvw_tab [6];
  ahs_row_type                 rows [10];
  int                          bad_count;
  int                          checks;
  int                          sec;

  ahs_top u_ahs_top (.core_clk_i(core_clk_i), .nrst_i(nrst_i), .angle_i(angle_i),
    .angle_valid_i(angle_valid_i), .self_test_done_i(self_test_done_i), .addr_i(addr_i),
    .wr_data_i(wr_data_i), .wr_i(wr_i), .rd_i(rd_i), .rd_data_o(rd_data_o),
    .enc_a_o(enc_a_o), .enc_b_o(enc_b_o), .enc_idx_o(enc_idx_o),
    .comm_u_o(comm_u_o), .comm_v_o(comm_v_o), .comm_w_o(comm_w_o));
  ahs_host_model u_ahs_host_model (.core_clk_i(core_clk_i), .nrst_i(nrst_i),
    .enc_a_i(enc_a_o), .enc_b_i(enc_b_o), .pos_o(host_pos), .err_o(host_err));

  initial
  begin
    core_clk_i = 1'b0;
    forever #2.5 core_clk_i = ~core_clk_i;
  end

  task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
    checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge core_clk_i);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [15:0] v);
    @(posedge core_clk_i);
    addr_i <= a;
    wr_data_i <= v;
    wr_i <= 1'b1;
    @(posedge core_clk_i);
    wr_i <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] a);
    @(posedge core_clk_i);
    addr_i <= a;
    rd_i <= 1'b1;
    @(posedge core_clk_i);
    rd_i <= 1'b0;
    #1;
    d = rd_data_o;
  endtask
  task automatic sample(input logic [13:0] a);
    @(posedge core_clk_i);
    angle_i <= a;
    angle_valid_i <= 1'b1;
    @(posedge core_clk_i);
    angle_valid_i <= 1'b0;
  endtask
  task automatic do_reset;
    @(posedge core_clk_i);
    nrst_i <= 1'b0;
    repeat (4) @(posedge core_clk_i);
    nrst_i <= 1'b1;
  endtask
  task automatic stop_test;
    $display("comparisons %0d mismatches %0d", checks, bad_count);
    if (bad_count == 0 && checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask

  initial
  begin
    #100000;
    bad_count++;
    stop_test();
  end

  initial
  begin
    {angle_i, angle_valid_i, self_test_done_i, addr_i, wr_data_i, wr_i, rd_i} = '0;
    nrst_i = 1'b0;
    bad_count = 0;
    checks = 0;
    uvw_tab = '{3'h5, 3'h4, 3'h6, 3'h2, 3'h3, 3'h1};
    rows[0] = '{14'd1000, 12'd250, 1'b0};
    rows[1] = '{14'd1040, 12'd260, 1'b0};
    rows[2] = '{14'd1036, 12'd260, 1'b0};
    rows[3] = '{14'd1031, 12'd257, 1'b1};
    rows[4] = '{14'd1020, 12'd255, 1'b1};
    rows[5] = '{14'd1027, 12'd255, 1'b1};
    rows[6] = '{14'd1029, 12'd257, 1'b0};
    rows[7] = '{14'd16380, 12'd4095, 1'b1};
    rows[8] = '{14'd4, 12'd4095, 1'b1};
    rows[9] = '{14'd6, 12'd1, 1'b0};
    do_reset();
    wr(8'h14, 16'hFFFF);
    for (int i = 0; i < 6; i++)
    begin
      rd(8'(4 * i));
      check("register reset", d, 16'h0000);
    end
    sample(14'd8);
    cyc(20);
    check("power-on lines", 16'({enc_a_o, enc_b_o, enc_idx_o}), 16'h0000);
    cyc(700);
    check("direct jump", 16'({enc_a_o, enc_b_o, enc_idx_o}), 16'h0006);
    rd(ahs_pkg::STAT_OFS);
    check("done after jump", 16'(d[1]), 16'h0001);
    do_reset();
    wr(ahs_pkg::STEP_OFS, 16'h0002);
    wr(ahs_pkg::HYST_OFS, 16'h0008);
    sample(14'd20);
    cyc(300);
    check("zero hold", 16'({enc_a_o, enc_b_o, enc_idx_o}), 16'h0001);
    for (int k = 0; k < 600 && enc_idx_o !== 1'b0; k++)
      cyc(1);
    cyc(3);
    check("slew limited", 16'(host_pos < 12'd5), 16'h0001);
    cyc(12);
    check("caught up", 16'(host_pos), 16'h0005);
    check("catch-up lines", 16'({enc_a_o, enc_b_o, enc_idx_o}), 16'h0004);
    rd(ahs_pkg::STAT_OFS);
    check("done after catch-up", 16'(d[1]), 16'h0001);
    for (int i = 0; i < 10; i++)
    begin
      sample(rows[i].ang);
      rd(ahs_pkg::FILT_OFS);
      check("filtered angle", d, 16'(rows[i].filt));
      rd(ahs_pkg::STAT_OFS);
      check("direction", 16'(d[0]), 16'(rows[i].dir));
    end
    sample(14'd16000);
    rd(ahs_pkg::STAT_OFS);
    check("direction before self-test", 16'(d[0]), 16'h0001);
    @(posedge core_clk_i);
    self_test_done_i <= 1'b1;
    @(posedge core_clk_i);
    self_test_done_i <= 1'b0;
    rd(ahs_pkg::STAT_OFS);
    check("direction after self-test", 16'(d[0]), 16'h0000);
    sample(14'd15996);
    sample(14'd15990);
    rd(ahs_pkg::FILT_OFS);
    check("window trails", d, 16'd3999);
    rd(ahs_pkg::STAT_OFS);
    check("no early reversal", 16'(d[0]), 16'h0000);
    wr(ahs_pkg::CFG_OFS, 16'h0010);
    cyc(4200);
    check("filtered to encoder", 16'({enc_a_o, enc_b_o, enc_idx_o}), 16'h0002);
    check("host position", 16'(host_pos), 16'd3999);
    wr(ahs_pkg::CFG_OFS, 16'h0000);
    cyc(20);
    check("raw to encoder", 16'({enc_a_o, enc_b_o, enc_idx_o}), 16'h0004);
    for (int f = 0; f < 16; f++)
    begin
      wr(ahs_pkg::CFG_OFS, 16'(f));
      cyc(3);
      sec = ((15990 * (f + 1)) % 16384) * 6 / 16384;
      check("commutation", 16'({comm_u_o, comm_v_o, comm_w_o}), 16'(uvw_tab[sec]));
    end
    wr(ahs_pkg::CFG_OFS, 16'h0010);
    cyc(6);
    wr(ahs_pkg::STEP_OFS, 16'h0000);
    cyc(3);
    check("filtered jump", 16'({enc_a_o, enc_b_o, enc_idx_o}), 16'h0002);
    wr(ahs_pkg::STEP_OFS, 16'h0003);
    sample(14'd15900);
    cyc(40);
    check("slow slew", 16'(host_pos > 12'd3975), 16'h0001);
    cyc(50);
    check("slew done", 16'(host_pos), 16'd3975);
    check("gray steps", 16'(host_err), 16'h0000);
    stop_test();
  end
endmodule
